// ===== include/blank_phase_defines.vh
// Function
// - Rising event blanks falling inputs for count
// - Falling event blanks rising inputs for count
// - Rising edge event delayed by phase count
// - Falling edge event delayed by phase count
// - Upper 26 bits read zero, ignore writes
// - Counts unknown at power-up, kept otherwise
//
// Purpose: constants for the blanking and phase delay block
// Assumes: AXI4-Lite, 32-bit data, one register per word
// Notes:   offsets are byte addresses
`ifndef BLANK_PHASE_DEFINES_VH
`define BLANK_PHASE_DEFINES_VH
`define CNT_W          6
`define ADDR_W         4
`define OFF_RISE_BLANK 4'h0
`define OFF_FALL_BLANK 4'h4
`define OFF_RISE_PHASE 4'h8
`define OFF_FALL_PHASE 4'hc
`define CNT_ZERO       6'h00
`define CNT_ONE        6'h01
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`define RDATA_PAD      26'h000_0000
`endif

// ===== logic/event_delay.v
// Purpose: delays a one-cycle event by a programmable count
// Assumes: events are single-cycle pulses
// Notes:   a new event while one is pending restarts the delay
`timescale 1ns/1ps
`include "blank_phase_defines.vh"
module event_delay (
  input  wire                aclk,
  input  wire                aresetn,
  input  wire                event_in,
  input  wire [`CNT_W-1:0]   delay_count,
  output wire                event_out
);
  reg              busy_ff;
  reg [`CNT_W-1:0] cnt_ff;
  reg              nxt_busy;
  reg [`CNT_W-1:0] nxt_cnt;
  reg              fire;

  always @* begin
    nxt_busy = busy_ff;
    nxt_cnt  = cnt_ff;
    fire     = 1'b0;
    if (event_in && delay_count == `CNT_ZERO) begin
      fire = 1'b1;
    end else if (event_in) begin
      nxt_busy = 1'b1;
      nxt_cnt  = delay_count;
    end else if (busy_ff) begin
      if (cnt_ff == `CNT_ONE) begin
        fire     = 1'b1;
        nxt_busy = 1'b0;
      end
      nxt_cnt = cnt_ff - `CNT_ONE;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'b0;
      cnt_ff  <= `CNT_ZERO;
    end else begin
      busy_ff <= nxt_busy;
      cnt_ff  <= nxt_cnt;
    end
  end

  // Combinational so zero delay passes in the same cycle
  assign event_out = fire;
endmodule // event_delay

// ===== logic/blank_phase_top.v
// Purpose: blanking and phase delay stage of an output generator
// Assumes: rise_in and fall_in are one-cycle pulses on aclk
// Notes:   outputs are registered, one cycle after the decision
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "blank_phase_defines.vh"
module blank_phase_top (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire [`ADDR_W-1:0] s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [`ADDR_W-1:0] s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire               rise_in,
  input  wire               fall_in,
  output reg                rise_out,
  output reg                fall_out
);
  // ----------------------------------------------------------
  // Count registers
  // ----------------------------------------------------------
  // No reset: value is unknown at power-up and kept across aresetn
  reg [`CNT_W-1:0] rise_blank_value_ff;
  reg [`CNT_W-1:0] fall_blank_value_ff;
  reg [`CNT_W-1:0] rise_phase_value_ff;
  reg [`CNT_W-1:0] fall_phase_value_ff;

  // ----------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------
  reg               aw_held_ff;
  reg [`ADDR_W-1:0] aw_addr_ff;
  reg               w_held_ff;
  reg [31:0]        w_data_ff;
  reg               w_strb0_ff;
  wire              aw_take = s_axi_awvalid && s_axi_awready;
  wire              w_take  = s_axi_wvalid && s_axi_wready;
  wire              do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  reg               wr_hit;

  always @* begin
    case (aw_addr_ff)
      `OFF_RISE_BLANK: wr_hit = 1'b1;
      `OFF_FALL_BLANK: wr_hit = 1'b1;
      `OFF_RISE_PHASE: wr_hit = 1'b1;
      `OFF_FALL_PHASE: wr_hit = 1'b1;
      default:         wr_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      aw_addr_ff    <= `OFF_RISE_BLANK;
      w_data_ff     <= 32'h0000_0000;
      w_strb0_ff    <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !aw_take;
      s_axi_wready  <= !w_held_ff && !w_take;
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only bits 5..0 are stored; upper bits are dropped
  always @(posedge aclk) begin
    if (do_write && w_strb0_ff) begin
      case (aw_addr_ff)
        `OFF_RISE_BLANK: rise_blank_value_ff <= w_data_ff[`CNT_W-1:0];
        `OFF_FALL_BLANK: fall_blank_value_ff <= w_data_ff[`CNT_W-1:0];
        `OFF_RISE_PHASE: rise_phase_value_ff <= w_data_ff[`CNT_W-1:0];
        `OFF_FALL_PHASE: fall_phase_value_ff <= w_data_ff[`CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------
  wire ar_take = s_axi_arvalid && s_axi_arready;
  reg [`CNT_W-1:0] rd_val;
  reg              rd_hit;

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFF_RISE_BLANK: rd_val = rise_blank_value_ff;
      `OFF_FALL_BLANK: rd_val = fall_blank_value_ff;
      `OFF_RISE_PHASE: rd_val = rise_phase_value_ff;
      `OFF_FALL_PHASE: rd_val = fall_phase_value_ff;
      default: begin
        rd_val = `CNT_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {`RDATA_PAD, rd_val};
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Blanking
  // ----------------------------------------------------------
  // Counters hold remaining blanked cycles; opposite event starts it
  reg  [`CNT_W-1:0] blank_fall_ff;   // falling inputs ignored while > 0
  reg  [`CNT_W-1:0] blank_rise_ff;   // rising inputs ignored while > 0
  wire rise_pass = rise_in && blank_rise_ff == `CNT_ZERO;
  wire fall_pass = fall_in && blank_fall_ff == `CNT_ZERO;

  always @(posedge aclk) begin
    if (!aresetn) begin
      blank_fall_ff <= `CNT_ZERO;
      blank_rise_ff <= `CNT_ZERO;
    end else begin
      if (rise_pass)
        blank_fall_ff <= rise_blank_value_ff;
      else if (blank_fall_ff != `CNT_ZERO)
        blank_fall_ff <= blank_fall_ff - `CNT_ONE;
      if (fall_pass)
        blank_rise_ff <= fall_blank_value_ff;
      else if (blank_rise_ff != `CNT_ZERO)
        blank_rise_ff <= blank_rise_ff - `CNT_ONE;
    end
  end

  // ----------------------------------------------------------
  // Phase delay
  // ----------------------------------------------------------
  wire rise_dly;
  wire fall_dly;

  event_delay u_rise_delay (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .event_in    (rise_pass),
    .delay_count (rise_phase_value_ff),
    .event_out   (rise_dly)
  );

  event_delay u_fall_delay (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .event_in    (fall_pass),
    .delay_count (fall_phase_value_ff),
    .event_out   (fall_dly)
  );

  // Registered so every output comes from a flip-flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      rise_out <= rise_dly;
      fall_out <= fall_dly;
    end
  end
endmodule // blank_phase_top

// ===== verif/bp_monitor.sv
// Purpose: port checker for blank_phase_top
// Assumes: outputs are one-cycle pulses
// Notes: gap counters saturate, so idle time never wraps
`timescale 1ns/1ps
module bp_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        rise_in,
  input wire        fall_in,
  input wire        rise_out,
  input wire        fall_out
);
  // ----
  // Edges since the last event of each kind
  // ----
  logic [6:0] rgap_ff;
  logic [6:0] fgap_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rgap_ff <= 7'h7f;
      fgap_ff <= 7'h7f;
    end else begin
      rgap_ff <= rise_in ? 7'h01 : rgap_ff + 7'(rgap_ff != 7'h7f);
      fgap_ff <= fall_in ? 7'h01 : fgap_ff + 7'(fgap_ff != 7'h7f);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // Checks
  // ----
  AST_RISE_CAUSE:
    assert property (rise_out |-> rgap_ff <= 7'h40)
    else $error("rise_out with no recent rise_in");
  AST_FALL_CAUSE:
    assert property (fall_out |-> fgap_ff <= 7'h40)
    else $error("fall_out with no recent fall_in");
  AST_RDATA_PAD:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("read data upper bits not zero");
  AST_B_STANDS:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_R_STANDS:
    assert property (s_axi_rvalid && !s_axi_rready
                     |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  AST_B_TIME:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                     && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_R_TIME:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  COV_RISE: cover property (rise_out);
  COV_FALL: cover property (fall_out);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule // bp_monitor
bind blank_phase_top bp_monitor u_mon (.*);

// ===== verif/event_source.sv
// Purpose: far-side model issuing rising and falling events
// Assumes: events are one-cycle pulses on aclk
// Notes: lines fall back low between pulses
`timescale 1ns/1ps
module event_source (
  input  wire aclk,
  output reg  rise_in,
  output reg  fall_in
);
  // ----
  // Event pulses
  // ----
  initial begin
    rise_in = 1'h0;
    fall_in = 1'h0;
  end
  // Wait g edges, then one pulse; g of one or more keeps drives apart
  task fire(input logic r, input logic f, input int g);
    repeat (g) @(posedge aclk);
    rise_in <= r;
    fall_in <= f;
    @(posedge aclk);
    rise_in <= 1'h0;
    fall_in <= 1'h0;
  endtask
endmodule // event_source

// ===== verif/tb.sv
// Purpose: self-checking bench for blank_phase_top
// Assumes: counts written before events
// Notes: byte addresses off the word grid answer SLVERR
`timescale 1ns/1ps
`include "blank_phase_defines.vh"
module tb;
  logic             aclk, aresetn, rise_in, fall_in, rise_out, fall_out;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  logic [3:0]       s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  int               mismatches, n_checks;
  logic [1:0]       exp_resp;
  blank_phase_top u_dut (.*);
  event_source u_src (.*);
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  // ----
  // Shared tasks
  // ----
  task chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'h0;
        ad = 1;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'h0;
        wd = 1;
      end
    end while (!(ad && wd));
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, exp_resp);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk({s_axi_rresp, s_axi_rdata}, {exp_resp, e});
  endtask
  // Edges until the chosen output pulses, 99 when none comes
  task wt(input logic s, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((s ? rise_out : fall_out) !== 1'h1 && n < 99);
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    for (int i = 0; i < 4; i++) wr(4'(i * 4), 32'hffff_ffff ^ i);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0000_003f ^ i);
  endtask
  // Strobe low stores nothing; a stray byte address answers SLVERR
  task t_refuse;
    wr(`OFF_RISE_BLANK, 32'h0000_0015);
    s_axi_wstrb <= 4'h0;
    wr(`OFF_RISE_BLANK, 32'h0000_002a);
    s_axi_wstrb <= 4'hf;
    rd(`OFF_RISE_BLANK, 32'h0000_0015);
    exp_resp = `RESP_SLVERR;
    wr(4'h1, 32'h0000_003f);
    rd(4'h1, 32'h0000_0000);
    exp_resp = `RESP_OKAY;
    rd(`OFF_RISE_BLANK, 32'h0000_0015);
  endtask
  task t_delay(input logic [5:0] p);
    int n;
    wr(`OFF_RISE_BLANK, 32'h0);
    wr(`OFF_FALL_BLANK, 32'h0);
    wr(`OFF_RISE_PHASE, {26'h0, p});
    wr(`OFF_FALL_PHASE, {26'h0, p});
    u_src.fire(1'h1, 1'h0, 1);
    wt(1'h1, n);
    chk(n, p + 1);
    u_src.fire(1'h0, 1'h1, 1);
    wt(1'h0, n);
    chk(n, p + 1);
  endtask
  // Blank of three: the opposite event at the third edge is dropped
  task t_blank(input logic s);
    int n;
    wr(`OFF_RISE_BLANK, s ? 32'h3 : 32'h0);
    wr(`OFF_FALL_BLANK, s ? 32'h0 : 32'h3);
    u_src.fire(s, !s, 1);
    u_src.fire(!s, s, 2);
    wt(!s, n);
    chk(n, 99);
    u_src.fire(s, !s, 1);
    u_src.fire(!s, s, 3);
    wt(!s, n);
    chk(n, 1);
  endtask
  task test_done;
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    test_done;
  end
  initial begin
    {mismatches, n_checks} = 0;
    exp_resp = `RESP_OKAY;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_refuse;
    t_delay(6'h3f);
    t_delay(6'h01);
    t_delay(6'h00);
    t_blank(1'h1);
    t_blank(1'h0);
    test_done;
  end
endmodule // tb
